/* File: dac_device_model.sv */
`timescale 1ns/1ps
module dac_device_model
  import dac_host_pkg::*;
(
  // Host bus.
  input wire logic [11:0] data_in,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic upper_nibble_select_n,
  input wire logic lower_byte_select_n,
  input wire logic load_converter_n,
  input wire logic zero_force_n,
  // Latch contents.
  output logic [11:0] in_latch,
  output logic [11:0] dac_code
);
  // The input latch follows the bus while its enables are low and keeps the last value.
  always @* begin
    if (!write_n && !chip_select_n && upper_nibble_select_n && lower_byte_select_n) begin
      in_latch = data_in;
    end
    if (!write_n && !lower_byte_select_n) begin
      in_latch[7:0] = data_in[7:0];
    end
    if (!write_n && !upper_nibble_select_n) begin
      in_latch[11:8] = data_in[3:0];
    end
  end
  // Clear wins over load; with neither low the code holds.
  always @* begin
    if (!zero_force_n) begin
      dac_code = code_zero;
    end else if (!load_converter_n) begin
      dac_code = in_latch;
    end
  end
endmodule

/* File: dac_host_pkg.sv */
package dac_host_pkg;

  localparam int code_width = 12;
  localparam int byte_width = 8;
  localparam int nibble_width = 4;
  localparam int nibble_lsb = 8;
  localparam logic [11:0] code_zero = 12'h000;
  localparam logic [7:0] byte_zero = 8'h00;

  // Strobe timing, in nanoseconds, at the 40 MHz reference clock.
  localparam int clk_period_ns = 25;
  localparam int setup_ns = 50;
  localparam int strobe_ns = 50;
  localparam int hold_ns = 25;
  localparam int setup_cycles = (setup_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int strobe_cycles = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int hold_cycles = (hold_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int cnt_width = 4;
  localparam logic [3:0] setup_cnt = 4'(setup_cycles);
  localparam logic [3:0] strobe_cnt = 4'(strobe_cycles);
  localparam logic [3:0] hold_cnt = 4'(hold_cycles);
  localparam logic [3:0] cnt_zero = 4'h0;

  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_setup = 4'b0001,
    st_write = 4'b0010,
    st_hold = 4'b0011,
    st_load = 4'b0100,
    st_load_hold = 4'b0101,
    st_clear = 4'b0110,
    st_clear_hold = 4'b0111
  } host_state_e;

  // Which portion a write cycle carries.
  typedef enum logic [1:0] {
    part_full = 2'b00,
    part_low = 2'b01,
    part_high = 2'b10
  } part_e;

  typedef struct packed {
    logic chip_select_n;
    logic write_n;
    logic upper_nibble_select_n;
    logic lower_byte_select_n;
    logic load_converter_n;
    logic zero_force_n;
  } strobes_s;

  localparam strobes_s strobes_idle = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

/* File: dac_port_host.sv */
`timescale 1ns/1ps
module dac_port_host
  import dac_host_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Command port.
  input wire logic cmd_valid,
  input wire logic [11:0] cmd_code,
  input wire logic cmd_byte_mode,
  input wire logic cmd_load,
  input wire logic cmd_clear,
  output logic cmd_ready,
  output logic cmd_done,
  // Device pins.
  output logic [11:0] data_out,
  output logic chip_select_n,
  output logic write_n,
  output logic upper_nibble_select_n,
  output logic lower_byte_select_n,
  output logic load_converter_n,
  output logic zero_force_n
);

  host_state_e state_r, state_nxt;
  part_e part_r, part_nxt;
  strobes_s pins_r, pins_nxt;
  logic [11:0] data_r, data_nxt;
  logic [11:0] code_r, code_nxt;
  logic byte_r, byte_nxt;
  logic load_r, load_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic tmr_load;
  logic [3:0] tmr_count;
  logic tmr_done;

  strobe_timer strobe_timer_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  function automatic logic [11:0] bus_word(input part_e p, input logic [11:0] c);
    logic [11:0] w;
    w = code_zero;
    case (p)
      part_full: w = c;
      part_low: w = {4'h0, c[byte_width-1:0]};
      default: w = {8'h00, c[code_width-1:nibble_lsb]};
    endcase
    return w;
  endfunction

  always_comb begin
    state_nxt = state_r;
    part_nxt = part_r;
    pins_nxt = pins_r;
    data_nxt = data_r;
    code_nxt = code_r;
    byte_nxt = byte_r;
    load_nxt = load_r;
    ready_nxt = 1'b0;
    done_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_count = setup_cnt;
    case (state_r)
      st_idle: begin
        ready_nxt = 1'b1;
        if (cmd_valid && ready_r) begin
          ready_nxt = 1'b0;
          code_nxt = cmd_code;
          byte_nxt = cmd_byte_mode;
          load_nxt = cmd_load;
          tmr_load = 1'b1;
          if (cmd_clear) begin
            pins_nxt.zero_force_n = 1'b0;
            tmr_count = strobe_cnt;
            state_nxt = st_clear;
          end else begin
            part_nxt = cmd_byte_mode ? part_low : part_full;
            data_nxt = bus_word(cmd_byte_mode ? part_low : part_full, cmd_code);
            pins_nxt.chip_select_n = 1'b0;
            // Byte select leads the write strobe, so the two never switch on one edge.
            pins_nxt.lower_byte_select_n = !cmd_byte_mode;
            state_nxt = st_setup;
          end
        end
      end
      st_setup: begin
        if (tmr_done) begin
          pins_nxt.write_n = 1'b0;
          tmr_load = 1'b1;
          tmr_count = strobe_cnt;
          state_nxt = st_write;
        end
      end
      st_write: begin
        if (tmr_done) begin
          pins_nxt.write_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = hold_cnt;
          state_nxt = st_hold;
        end
      end
      st_hold: begin
        if (tmr_done) begin
          pins_nxt = strobes_idle;
          tmr_load = 1'b1;
          if (byte_r && part_r == part_low) begin
            part_nxt = part_high;
            data_nxt = bus_word(part_high, code_r);
            pins_nxt.upper_nibble_select_n = 1'b0;
            pins_nxt.chip_select_n = 1'b0;
            tmr_count = setup_cnt;
            state_nxt = st_setup;
          end else if (load_r) begin
            pins_nxt.load_converter_n = 1'b0;
            tmr_count = strobe_cnt;
            state_nxt = st_load;
          end else begin
            done_nxt = 1'b1;
            state_nxt = st_idle;
          end
        end
      end
      st_load: begin
        if (tmr_done) begin
          pins_nxt.load_converter_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = hold_cnt;
          state_nxt = st_load_hold;
        end
      end
      st_clear: begin
        if (tmr_done) begin
          pins_nxt.zero_force_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = hold_cnt;
          state_nxt = st_clear_hold;
        end
      end
      default: begin
        if (tmr_done) begin
          done_nxt = 1'b1;
          state_nxt = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= st_idle;
      part_r <= part_full;
      pins_r <= strobes_idle;
      data_r <= code_zero;
      code_r <= code_zero;
      byte_r <= 1'b0;
      load_r <= 1'b0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      part_r <= part_nxt;
      pins_r <= pins_nxt;
      data_r <= data_nxt;
      code_r <= code_nxt;
      byte_r <= byte_nxt;
      load_r <= load_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
    end
  end

  assign data_out = data_r;
  assign chip_select_n = pins_r.chip_select_n;
  assign write_n = pins_r.write_n;
  assign upper_nibble_select_n = pins_r.upper_nibble_select_n;
  assign lower_byte_select_n = pins_r.lower_byte_select_n;
  assign load_converter_n = pins_r.load_converter_n;
  assign zero_force_n = pins_r.zero_force_n;
  assign cmd_ready = ready_r;
  assign cmd_done = done_r;

  write_needs_cs_a: assert property (@(posedge ref_clk) disable iff (rst)
    !write_n |-> !chip_select_n) else $error("write strobe without chip select");
  write_with_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(write_n) |-> $past(!chip_select_n)) else $error("write before select setup");
  one_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    !write_n |-> (upper_nibble_select_n || lower_byte_select_n))
    else $error("both byte selects low");
  data_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(write_n) |-> ($stable(data_out) && !chip_select_n))
    else $error("data moved at write edge");
  nibble_just_a: assert property (@(posedge ref_clk) disable iff (rst)
    !upper_nibble_select_n |-> data_out[11:4] == 8'h00)
    else $error("upper nibble not right justified");
  low_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
    !lower_byte_select_n |-> data_out[7:0] == code_r[7:0]) else $error("low byte wrong");
  full_word_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!write_n && lower_byte_select_n && upper_nibble_select_n) |-> data_out == code_r)
    else $error("parallel word wrong");
  load_alone_a: assert property (@(posedge ref_clk) disable iff (rst)
    !load_converter_n |-> (write_n && chip_select_n)) else $error("load during write");
  clear_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(zero_force_n) |-> !zero_force_n [*2] ##1 zero_force_n)
    else $error("clear pulse length wrong");
  load_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(load_converter_n) |-> !load_converter_n [*2] ##1 load_converter_n)
    else $error("load pulse length wrong");

endmodule

/* File: dual_latch_dac_input_port_bench.sv */
`timescale 1ns/1ps
`define CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end
module dual_latch_dac_input_port_bench;
  import dac_host_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [11:0] cmd_code = 12'h000;
  logic cmd_byte_mode = 1'b0;
  logic cmd_load = 1'b0;
  logic cmd_clear = 1'b0;
  logic cmd_ready, cmd_done, cs_n, wr_n, up_n, lo_n, ld_n, clr_n;
  logic [11:0] data_out, in_latch, dac_code;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  dac_port_host dac_port_host_inst (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_byte_mode(cmd_byte_mode), .cmd_load(cmd_load),
    .cmd_clear(cmd_clear), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .data_out(data_out),
    .chip_select_n(cs_n), .write_n(wr_n), .upper_nibble_select_n(up_n),
    .lower_byte_select_n(lo_n), .load_converter_n(ld_n), .zero_force_n(clr_n));
  dac_device_model dac_device_model_inst (.data_in(data_out), .chip_select_n(cs_n),
    .write_n(wr_n), .upper_nibble_select_n(up_n), .lower_byte_select_n(lo_n),
    .load_converter_n(ld_n), .zero_force_n(clr_n), .in_latch(in_latch), .dac_code(dac_code));
  task report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task run_cmd(input logic [11:0] code, input logic bm, input logic ld, input logic cl);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    cmd_code = code;
    cmd_byte_mode = bm;
    cmd_load = ld;
    cmd_clear = cl;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    `CHECK(cmd_done, 1'b1)
  endtask
  // Every write strobe must be qualified by exactly one byte select in byte mode, and by chip select otherwise.
  always @(negedge ref_clk) begin
    if (!rst && wr_n === 1'b0) begin
      if (cmd_byte_mode) begin
        `CHECK(up_n ^ lo_n, 1'b1)
      end else begin
        `CHECK(cs_n, 1'b0)
      end
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task t_parallel_load();
    run_cmd(12'ha5c, 1'b0, 1'b1, 1'b0);
    `CHECK(dac_code, 12'ha5c)
  endtask
  task t_parallel_hold();
    run_cmd(12'h3c1, 1'b0, 1'b0, 1'b0);
    `CHECK(in_latch, 12'h3c1)
    `CHECK(dac_code, 12'ha5c)
  endtask
  task t_byte_load();
    run_cmd(12'h7e9, 1'b1, 1'b1, 1'b0);
    `CHECK(dac_code, 12'h7e9)
    run_cmd(12'h8f0, 1'b1, 1'b0, 1'b0);
    `CHECK(in_latch, 12'h8f0)
    `CHECK(dac_code, 12'h7e9)
  endtask
  task t_clear();
    run_cmd(12'hfff, 1'b0, 1'b1, 1'b0);
    `CHECK(dac_code, 12'hfff)
    run_cmd(12'h555, 1'b0, 1'b1, 1'b1);
    `CHECK(dac_code, code_zero)
    `CHECK(in_latch, 12'hfff)
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    `CHECK({cs_n, wr_n, up_n, lo_n, ld_n, clr_n}, 6'h3f)
    `CHECK(data_out, code_zero)
    `CHECK(cmd_ready, 1'b0)
    rst = 1'b0;
    t_parallel_load();
    t_parallel_hold();
    t_byte_load();
    t_clear();
    report_and_stop();
  end
endmodule

/* File: strobe_timer.sv */
`timescale 1ns/1ps
module strobe_timer
  import dac_host_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Control.
  input wire logic load,
  input wire logic [3:0] count,
  output logic done
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = count;
    end else if (cnt_r != cnt_zero) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= cnt_zero;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done depends on the count alone, so the caller may reload on done without a loop.
  assign done = (cnt_r == 4'h1 || cnt_r == cnt_zero);

endmodule
